// file: verilog/fgr_defines.svh
// constants of the fine granularity refresh controller
// Overview of operation
// - single refresh every base interval, single cycle time
// - faster rates shorten interval; hot halves it again
// - base interval 7.8 us; cycle 260/160/110 ns
// - fixed mode issues only its own refresh type
// - on-the-fly mixes single with its fast type only
// - new rate timing applies from the change onward
// - double count even before rate-changing mode write
// - even double refreshes between two single refreshes
// - quad count multiple of four before rate change
// - quad refreshes between singles multiple of four
// - fixed/on-the-fly switch at same rate is no change
// - temperature controlled refresh only with fixed single rate
// - unbalanced double count: one single or two doubles after exit
// - unbalanced quad count: one single or four quads after exit
// - extra refreshes after exit not counted in interval
`ifndef FGR_DEFINES_SVH
`define FGR_DEFINES_SVH
// timing, in ns, and cycle conversions at the core clock
`define FGR_CLK_PERIOD_NS 10
`define FGR_AVG_REFRESH_INTERVAL_BASE_NS 7800
`define FGR_TRFC1_NS 260
`define FGR_TRFC2_NS 160
`define FGR_TRFC4_NS 110
`define FGR_AVG_REFRESH_INTERVAL_CYC (`FGR_AVG_REFRESH_INTERVAL_BASE_NS / `FGR_CLK_PERIOD_NS)
`define FGR_CEIL_CYC(ns) (((ns) + `FGR_CLK_PERIOD_NS - 1) / `FGR_CLK_PERIOD_NS)
`define FGR_CMD_WAIT_CYC 24
`define FGR_OWED_MAX 4'h8
// register word offsets
`define FGR_REG_CTRL 2'h0
`define FGR_REG_MODE 2'h1
`define FGR_REG_CMD 2'h2
`define FGR_REG_STAT 2'h3
// control fields and reset values
`define FGR_CTRL_REF_EN 0
`define FGR_CTRL_TEMP_HI 1
`define FGR_CTRL_TCR 2
`define FGR_CTRL_OTF_FAST 3
`define FGR_CTRL_RESET 4'h1
`define FGR_MODE_RESET 3'h0
`define FGR_MODE_PEND 8
// command fields
`define FGR_CMDREG_SRE 0
`define FGR_CMDREG_SRX 1
// status fields (lsb positions)
`define FGR_STAT_STATE 0
`define FGR_STAT_FAST 2
`define FGR_STAT_OWED 4
`define FGR_STAT_EXTRA 8
`define FGR_STAT_SELF 12
`define FGR_STAT_ERR_RSV 16
`define FGR_STAT_ERR_TCR 17
`endif

// file: verilog/fgr_pkg.sv
// types of the fine granularity refresh controller
package fgr_pkg;
    typedef enum logic [1:0] {
        FGR_RATE_1X = 2'h0,
        FGR_RATE_2X = 2'h1,
        FGR_RATE_4X = 2'h2,
        FGR_RATE_RSV = 2'h3
    } fgr_rate_t;
    typedef enum logic [2:0] {
        FGR_MODE_FIXED1X = 3'h0,
        FGR_MODE_FIXED2X = 3'h1,
        FGR_MODE_FIXED4X = 3'h2,
        FGR_MODE_OTF2X = 3'h5,
        FGR_MODE_OTF4X = 3'h6
    } fgr_mode_t;
    typedef enum logic [1:0] {
        FGR_CMD_REF = 2'h0,
        FGR_CMD_MRS = 2'h1,
        FGR_CMD_SRE = 2'h2,
        FGR_CMD_SRX = 2'h3
    } fgr_cmd_t;
    typedef enum logic [1:0] {
        FGR_ST_IDLE = 2'b00,
        FGR_ST_REF = 2'b01,
        FGR_ST_WAIT = 2'b11,
        FGR_ST_SELF = 2'b10
    } fgr_state_t;
    // fast refresh count balanced for the given rate
    function automatic logic fgr_balanced(input fgr_rate_t rate, input logic [1:0] cnt);
        return (rate == FGR_RATE_2X) ? ~cnt[0] : (rate == FGR_RATE_4X) ? (cnt == 2'h0) : 1'b1;
    endfunction : fgr_balanced
    // rate pattern is one of the five defined modes
    function automatic logic fgr_mode_legal(input logic [2:0] m);
        return (m == FGR_MODE_FIXED1X) || (m == FGR_MODE_FIXED2X) || (m == FGR_MODE_FIXED4X) ||
            (m == FGR_MODE_OTF2X) || (m == FGR_MODE_OTF4X);
    endfunction : fgr_mode_legal
endpackage : fgr_pkg

// file: verilog/fgr_timer.sv
// loadable down counter used for refresh interval and cycle waits
`timescale 1ns/1ps
`default_nettype none
module fgr_timer #(
    parameter int WIDTH = 10
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // control
    input wire logic load_in,
    input wire logic [WIDTH-1:0] load_val_in,
    // state
    output logic zero_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // load wins, otherwise count down to zero and hold
    always_comb begin
        next_count = count;
        if (load_in) begin
            next_count = load_val_in;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    // count register
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign zero_out = (count == '0);
endmodule : fgr_timer
`default_nettype wire

// file: verilog/fgr_ctrl.sv
// refresh scheduler that drives a ddr4 device with fine granularity refresh
`timescale 1ns/1ps
`default_nettype none
`include "fgr_defines.svh"
module fgr_ctrl #(
    parameter int AVG_REFRESH_INTERVAL_CYC = `FGR_AVG_REFRESH_INTERVAL_CYC,
    parameter int CMD_WAIT_CYC = `FGR_CMD_WAIT_CYC
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // avalon-mm slave
    input wire logic [1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // device command side
    output logic dev_cmd_valid_out,
    output var fgr_pkg::fgr_cmd_t dev_cmd_out,
    output logic bank_group_bit_zero_out,
    output logic [2:0] training_refresh_mode_reg_out,
    output logic temp_controlled_refresh_out
);
    import fgr_pkg::*;

    localparam int IV_W = $clog2(AVG_REFRESH_INTERVAL_CYC + 1);
    localparam int CYC_W = 8;
    localparam int RFC1_CYC = `FGR_CEIL_CYC(`FGR_TRFC1_NS);
    localparam int RFC2_CYC = `FGR_CEIL_CYC(`FGR_TRFC2_NS);
    localparam int RFC4_CYC = `FGR_CEIL_CYC(`FGR_TRFC4_NS);

    logic [3:0] ctrl, next_ctrl;
    logic [2:0] mode_cur, next_mode_cur, mode_new, next_mode_new;
    logic mode_pend, next_mode_pend, sre_pend, next_sre_pend, srx_pend, next_srx_pend;
    logic err_rsv, next_err_rsv, err_tcr, next_err_tcr;
    logic [1:0] fast_cnt, next_fast_cnt;
    logic [3:0] owed, next_owed;
    logic [2:0] extra_cnt, next_extra_cnt;
    fgr_state_t state, next_state;
    fgr_rate_t ref_kind, next_ref_kind, last_kind, next_last_kind, ref_k, rate_cur;
    logic cmd_valid, next_cmd_valid, bg0, next_bg0;
    fgr_cmd_t cmd, next_cmd;
    logic [2:0] mr_bits, next_mr_bits;
    logic [31:0] rdata, next_rdata;
    logic rd_valid, next_rd_valid;
    logic iv_zero, iv_load, cyc_zero, cyc_load, issue_ref, take_owed;
    logic otf, bal, rate_chg, tick, wr_ctrl, wr_mode, wr_cmd, wr_stat;
    logic [IV_W-1:0] iv_val;
    logic [CYC_W-1:0] cyc_val;

    // refresh cycle time of a refresh type, less the issue cycle
    function automatic logic [CYC_W-1:0] rfc_of(input fgr_rate_t k);
        return (k == FGR_RATE_2X) ? CYC_W'(RFC2_CYC - 1) :
            (k == FGR_RATE_4X) ? CYC_W'(RFC4_CYC - 1) : CYC_W'(RFC1_CYC - 1);
    endfunction : rfc_of

    // average interval of a refresh type, halved again when hot
    function automatic logic [IV_W-1:0] iv_of(input fgr_rate_t k, input logic hot);
        int s;
        s = ((k == FGR_RATE_2X) ? 1 : (k == FGR_RATE_4X) ? 2 : 0) + (hot ? 1 : 0);
        return IV_W'((AVG_REFRESH_INTERVAL_CYC >> s) - 1);
    endfunction : iv_of

    // interval and cycle timers
    fgr_timer #(.WIDTH(IV_W)) u_iv (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(iv_load),
        .load_val_in(iv_val),
        .zero_out(iv_zero)
    );
    fgr_timer #(.WIDTH(CYC_W)) u_cyc (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .load_in(cyc_load),
        .load_val_in(cyc_val),
        .zero_out(cyc_zero)
    );

    // decode of the programmed mode and bus strobes
    assign rate_cur = fgr_rate_t'(mode_cur[1:0]);
    assign otf = mode_cur[2];
    assign bal = fgr_balanced(rate_cur, fast_cnt);
    assign rate_chg = (mode_new[1:0] != mode_cur[1:0]);
    assign tick = iv_zero && ctrl[`FGR_CTRL_REF_EN] && (state != FGR_ST_SELF);
    assign wr_ctrl = avs_write_in && (avs_address_in == `FGR_REG_CTRL);
    assign wr_mode = avs_write_in && (avs_address_in == `FGR_REG_MODE);
    assign wr_cmd = avs_write_in && (avs_address_in == `FGR_REG_CMD);
    assign wr_stat = avs_write_in && (avs_address_in == `FGR_REG_STAT);

    // register writes, scheduling and command issue
    always_comb begin
        next_ctrl = ctrl;
        next_mode_cur = mode_cur;
        next_mode_new = mode_new;
        next_mode_pend = mode_pend;
        next_sre_pend = sre_pend;
        next_srx_pend = srx_pend;
        next_err_rsv = err_rsv;
        next_err_tcr = err_tcr;
        next_fast_cnt = fast_cnt;
        next_owed = owed;
        next_extra_cnt = extra_cnt;
        next_state = state;
        next_ref_kind = ref_kind;
        next_last_kind = last_kind;
        next_cmd_valid = 1'b0;
        next_cmd = cmd;
        next_bg0 = bg0;
        next_mr_bits = mr_bits;
        iv_load = iv_zero;
        cyc_load = 1'b0;
        cyc_val = '0;
        issue_ref = 1'b0;
        take_owed = 1'b0;
        ref_k = rate_cur;
        // error flags clear on write of one; sets below win
        if (wr_stat) begin
            next_err_rsv = err_rsv & ~avs_writedata_in[`FGR_STAT_ERR_RSV];
            next_err_tcr = err_tcr & ~avs_writedata_in[`FGR_STAT_ERR_TCR];
        end
        if (wr_ctrl) begin
            next_ctrl = avs_writedata_in[3:0];
            if (avs_writedata_in[`FGR_CTRL_TCR] && ((mode_cur != FGR_MODE_FIXED1X) || mode_pend)) begin
                next_ctrl[`FGR_CTRL_TCR] = 1'b0;
                next_err_tcr = 1'b1;
            end
        end
        if (wr_mode && !mode_pend) begin
            if (!fgr_mode_legal(avs_writedata_in[2:0])) begin
                next_err_rsv = 1'b1;
            end else if (ctrl[`FGR_CTRL_TCR] && (avs_writedata_in[2:0] != FGR_MODE_FIXED1X)) begin
                next_err_tcr = 1'b1;
            end else begin
                next_mode_new = avs_writedata_in[2:0];
                next_mode_pend = 1'b1;
            end
        end
        if (wr_cmd && avs_writedata_in[`FGR_CMDREG_SRE] && (state != FGR_ST_SELF)) begin
            next_sre_pend = 1'b1;
        end
        if (wr_cmd && avs_writedata_in[`FGR_CMDREG_SRX] && (state == FGR_ST_SELF)) begin
            next_srx_pend = 1'b1;
        end
        unique case (state)
            FGR_ST_IDLE: begin
                if (extra_cnt != 3'h0) begin
                    // post-exit top-up, outside the interval accounting
                    issue_ref = 1'b1;
                    ref_k = otf ? FGR_RATE_1X : rate_cur;
                    next_extra_cnt = extra_cnt - 3'h1;
                end else if (mode_pend) begin
                    if (bal || !rate_chg) begin
                        next_cmd_valid = 1'b1;
                        next_cmd = FGR_CMD_MRS;
                        next_mr_bits = mode_new;
                        next_mode_cur = mode_new;
                        next_mode_pend = 1'b0;
                        next_fast_cnt = 2'h0;
                        next_last_kind = fgr_rate_t'(mode_new[1:0]);
                        iv_load = 1'b1;
                        cyc_load = 1'b1;
                        cyc_val = CYC_W'(CMD_WAIT_CYC - 1);
                        next_state = FGR_ST_WAIT;
                    end else begin
                        // balance the fast count before the rate changes
                        issue_ref = 1'b1;
                    end
                end else if (sre_pend) begin
                    next_cmd_valid = 1'b1;
                    next_cmd = FGR_CMD_SRE;
                    next_sre_pend = 1'b0;
                    next_state = FGR_ST_SELF;
                end else if ((owed != 4'h0) && ctrl[`FGR_CTRL_REF_EN]) begin
                    issue_ref = 1'b1;
                    take_owed = 1'b1;
                    // single only while the fast count is balanced
                    if (otf && !ctrl[`FGR_CTRL_OTF_FAST] && bal) begin
                        ref_k = FGR_RATE_1X;
                    end else begin
                        ref_k = rate_cur;
                    end
                end
            end
            FGR_ST_REF, FGR_ST_WAIT: begin
                if (cyc_zero) begin
                    next_state = FGR_ST_IDLE;
                end
            end
            FGR_ST_SELF: begin
                if (srx_pend) begin
                    next_cmd_valid = 1'b1;
                    next_cmd = FGR_CMD_SRX;
                    next_srx_pend = 1'b0;
                    if (!bal) begin
                        next_extra_cnt = otf ? 3'h1 : (rate_cur == FGR_RATE_2X) ? 3'h2 : 3'h4;
                    end
                    next_fast_cnt = 2'h0;
                    iv_load = 1'b1;
                    cyc_load = 1'b1;
                    cyc_val = CYC_W'(CMD_WAIT_CYC - 1);
                    next_state = FGR_ST_WAIT;
                end
            end
        endcase
        if (issue_ref) begin
            next_cmd_valid = 1'b1;
            next_cmd = FGR_CMD_REF;
            next_ref_kind = ref_k;
            next_bg0 = otf && (ref_k != FGR_RATE_1X);
            next_fast_cnt = (ref_k == FGR_RATE_1X) ? 2'h0 : fast_cnt + 2'h1;
            next_last_kind = ref_k;
            if (ref_k != last_kind) begin
                iv_load = 1'b1;
            end
            cyc_load = 1'b1;
            cyc_val = rfc_of(ref_k);
            next_state = FGR_ST_REF;
        end
        // owed refreshes: a tick in the same cycle as a take is kept
        if (take_owed) begin
            next_owed = owed - 4'h1;
        end
        if (tick && (next_owed != `FGR_OWED_MAX)) begin
            next_owed = next_owed + 4'h1;
        end
        if (next_cmd_valid && (next_cmd == FGR_CMD_SRE)) begin
            next_owed = 4'h0;
        end
        iv_val = iv_of(next_last_kind, ctrl[`FGR_CTRL_TEMP_HI]);
    end

    // control registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= `FGR_CTRL_RESET;
            mode_cur <= `FGR_MODE_RESET;
            mode_new <= `FGR_MODE_RESET;
            mode_pend <= 1'b0;
            sre_pend <= 1'b0;
            srx_pend <= 1'b0;
            err_rsv <= 1'b0;
            err_tcr <= 1'b0;
            fast_cnt <= 2'h0;
            owed <= 4'h0;
            extra_cnt <= 3'h0;
            state <= FGR_ST_IDLE;
            ref_kind <= FGR_RATE_1X;
            last_kind <= FGR_RATE_1X;
            cmd_valid <= 1'b0;
            cmd <= FGR_CMD_REF;
            bg0 <= 1'b0;
            mr_bits <= `FGR_MODE_RESET;
        end else begin
            ctrl <= next_ctrl;
            mode_cur <= next_mode_cur;
            mode_new <= next_mode_new;
            mode_pend <= next_mode_pend;
            sre_pend <= next_sre_pend;
            srx_pend <= next_srx_pend;
            err_rsv <= next_err_rsv;
            err_tcr <= next_err_tcr;
            fast_cnt <= next_fast_cnt;
            owed <= next_owed;
            extra_cnt <= next_extra_cnt;
            state <= next_state;
            ref_kind <= next_ref_kind;
            last_kind <= next_last_kind;
            cmd_valid <= next_cmd_valid;
            cmd <= next_cmd;
            bg0 <= next_bg0;
            mr_bits <= next_mr_bits;
        end
    end

    // read data, one wait cycle per read
    always_comb begin
        next_rdata = rdata;
        next_rd_valid = avs_read_in && !rd_valid;
        if (avs_read_in && !rd_valid) begin
            next_rdata = 32'h0;
            unique case (avs_address_in)
                `FGR_REG_CTRL: next_rdata[3:0] = ctrl;
                `FGR_REG_MODE: begin
                    next_rdata[2:0] = mode_cur;
                    next_rdata[`FGR_MODE_PEND] = mode_pend;
                end
                `FGR_REG_CMD: begin
                    next_rdata[`FGR_CMDREG_SRE] = sre_pend;
                    next_rdata[`FGR_CMDREG_SRX] = srx_pend;
                end
                `FGR_REG_STAT: begin
                    next_rdata[`FGR_STAT_STATE +: 2] = state;
                    next_rdata[`FGR_STAT_FAST +: 2] = fast_cnt;
                    next_rdata[`FGR_STAT_OWED +: 4] = owed;
                    next_rdata[`FGR_STAT_EXTRA +: 3] = extra_cnt;
                    next_rdata[`FGR_STAT_SELF] = (state == FGR_ST_SELF);
                    next_rdata[`FGR_STAT_ERR_RSV] = err_rsv;
                    next_rdata[`FGR_STAT_ERR_TCR] = err_tcr;
                end
            endcase
        end
    end

    // read data registers
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata <= 32'h0;
            rd_valid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rd_valid <= next_rd_valid;
        end
    end

    // outputs
    assign avs_readdata_out = rdata;
    assign avs_waitrequest_out = avs_read_in && !rd_valid;
    assign dev_cmd_valid_out = cmd_valid;
    assign dev_cmd_out = cmd;
    assign bank_group_bit_zero_out = bg0;
    assign training_refresh_mode_reg_out = mr_bits;
    assign temp_controlled_refresh_out = ctrl[`FGR_CTRL_TCR];

    // helper: cycles since the last command and the spacing it demands
    logic [CYC_W-1:0] gap, req;
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap <= '1;
            req <= '0;
        end else begin
            gap <= cmd_valid ? CYC_W'(1) : ((gap == '1) ? gap : gap + 1'b1);
            if (cmd_valid) begin
                req <= (cmd == FGR_CMD_REF) ? rfc_of(ref_kind) + 1'b1 : CYC_W'(0);
            end
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    fixed_ref_kind_a: assert property (
        (cmd_valid && cmd == FGR_CMD_REF && !otf) |-> (ref_kind == rate_cur)
    ) else $error("fixed mode issued a foreign refresh type");
    otf_ref_mix_a: assert property (
        (cmd_valid && cmd == FGR_CMD_REF && otf) |-> (ref_kind == FGR_RATE_1X || ref_kind == rate_cur)
    ) else $error("on-the-fly mode issued a foreign refresh type");
    otf_bank_bit_a: assert property (
        (cmd_valid && cmd == FGR_CMD_REF && otf) |-> (bank_group_bit_zero_out == (ref_kind != FGR_RATE_1X))
    ) else $error("bank group bit zero does not match refresh type");
    single_balance_a: assert property (
        (cmd_valid && cmd == FGR_CMD_REF && otf && ref_kind == FGR_RATE_1X && $past(cmd) != FGR_CMD_SRX)
            |-> fgr_balanced(rate_cur, $past(fast_cnt))
    ) else $error("single refresh with unbalanced fast count");
    mrs_balance_a: assert property (
        (cmd_valid && cmd == FGR_CMD_MRS && $past(mode_cur[1:0]) != mode_cur[1:0])
            |-> fgr_balanced(fgr_rate_t'($past(mode_cur[1:0])), $past(fast_cnt))
    ) else $error("rate changed with unbalanced fast count");
    mrs_legal_a: assert property (
        (cmd_valid && cmd == FGR_CMD_MRS) |-> fgr_mode_legal(training_refresh_mode_reg_out)
    ) else $error("reserved rate pattern programmed");
    tcr_fixed_a: assert property (
        temp_controlled_refresh_out |-> (mode_cur == FGR_MODE_FIXED1X && !mode_pend)
    ) else $error("temperature controlled refresh outside fixed single mode");
    cmd_spacing_a: assert property (
        cmd_valid |-> (gap >= req)
    ) else $error("command inside refresh cycle time");
    exit_topup_a: assert property (
        (cmd_valid && cmd == FGR_CMD_SRX && !fgr_balanced(rate_cur, $past(fast_cnt)))
            |-> ##[1:100] (cmd_valid && cmd == FGR_CMD_REF)
    ) else $error("no extra refresh after self refresh exit");
    fast_clear_a: assert property (
        (cmd_valid && (cmd == FGR_CMD_MRS || cmd == FGR_CMD_SRX ||
            (cmd == FGR_CMD_REF && ref_kind == FGR_RATE_1X))) |-> (fast_cnt == 2'h0)
    ) else $error("fast count not cleared");
endmodule : fgr_ctrl
`default_nettype wire

// file: bench/fgr_dev_model.sv
// behavioural ddr4 refresh model checking command spacing and balance
`timescale 1ns/1ps
`default_nettype none
module fgr_dev_model (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // commands
    input wire logic cmd_valid_in,
    input wire fgr_pkg::fgr_cmd_t cmd_in,
    input wire logic bg0_in,
    input wire logic [2:0] mode_in,
    // findings
    output int viol_out,
    output int ref_cnt_out
);
    import fgr_pkg::*;
    logic [2:0] mode;
    logic [1:0] rate, fast;
    logic unbal;
    int gap, need, owe;
    // refresh rate from the fixed field, or from bank group bit zero on the fly
    assign rate = mode[2] ? (bg0_in ? mode[1:0] : 2'h0) : mode[1:0];
    assign unbal = mode[0] ? fast[0] : (fast != 2'h0);
    // spacing, rate changes and fast refresh count
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode <= 3'h0;
            fast <= 2'h0;
            gap <= 1000;
            need <= 0;
            owe <= 0;
            viol_out <= 0;
            ref_cnt_out <= 0;
        end else if (cmd_valid_in) begin
            gap <= 1;
            need <= 0;
            if (gap < need) viol_out <= viol_out + 1;
            if (owe != 0 && cmd_in != FGR_CMD_REF) viol_out <= viol_out + 1;
            if (cmd_in == FGR_CMD_REF) begin
                if (owe != 0) owe <= (rate == 2'h0) ? 0 : owe - 1;
                ref_cnt_out <= ref_cnt_out + 1;
                need <= (rate == 2'h0) ? 26 : (rate == 2'h1) ? 16 : 11;
                fast <= (rate == 2'h0) ? 2'h0 : fast + 2'h1;
                if (mode[2] && rate == 2'h0 && unbal) viol_out <= viol_out + 1;
            end else if (cmd_in == FGR_CMD_MRS) begin
                if (mode_in[1:0] != mode[1:0] && unbal) viol_out <= viol_out + 1;
                mode <= mode_in;
                fast <= 2'h0;
            end else if (cmd_in == FGR_CMD_SRX) begin
                fast <= 2'h0;
                // unbalanced entry owes one single or a full group of fast refreshes
                if (unbal) owe <= mode[2] ? 1 : (mode[0] ? 2 : 4);
            end
        end else begin
            gap <= gap + 1;
            if (owe != 0 && gap == 100) viol_out <= viol_out + 1;
        end
    end
endmodule : fgr_dev_model
`default_nettype wire

// file: bench/tb_top.sv
// bench for the fine granularity refresh controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fgr_pkg::*;
    localparam int AVG_REFRESH_INTERVAL = 256;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wreq, cv, bg0, temp_controlled_refresh;
    logic [1:0] adr = 2'h0;
    logic [2:0] mr, mv[5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6}, rsv[3] = '{3'h3, 3'h4, 3'h7};
    logic [31:0] wd = 32'h0, rdat, q, exp_q[$], msk_q[$];
    int error_cnt = 0, check_count = 0, cyc = 0, viol, refs, r0, e;
    fgr_cmd_t cmd;
    logic rd_n = 1'b0, wreq_n = 1'b1;
    logic [31:0] rdat_n = 32'h0;
    fgr_ctrl #(.AVG_REFRESH_INTERVAL_CYC(AVG_REFRESH_INTERVAL), .CMD_WAIT_CYC(4)) fgr_ctrl_i (.ref_clk_in(clk), .rst_n_in(rst_n),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .dev_cmd_valid_out(cv), .dev_cmd_out(cmd),
        .bank_group_bit_zero_out(bg0), .training_refresh_mode_reg_out(mr), .temp_controlled_refresh_out(temp_controlled_refresh));
    fgr_dev_model fgr_dev_model_i (.ref_clk_in(clk), .rst_n_in(rst_n), .cmd_valid_in(cv), .cmd_in(cmd),
        .bg0_in(bg0), .mode_in(mr), .viol_out(viol), .ref_cnt_out(refs));
    // 100 mhz clock
    always #5 clk = ~clk;
    // bus answers as they stand before each rising edge, free of edge races
    always @(negedge clk) begin
        rd_n <= rd;
        wreq_n <= wreq;
        rdat_n <= rdat;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
        wr <= 1'b1;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wreq_n !== 1'b0);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    // read with the expectation noted for the monitor
    task automatic rd_reg(input logic [1:0] a, input logic [31:0] m, input logic [31:0] x);
        exp_q.push_back(x);
        msk_q.push_back(m);
        rd <= 1'b1;
        adr <= a;
        do @(posedge clk); while (wreq_n !== 1'b0);
        q = rdat_n;
        rd <= 1'b0;
        @(posedge clk);
    endtask : rd_reg
    task automatic poll(input logic [1:0] a, input logic [31:0] m, input logic [31:0] v);
        q = ~v;
        while ((q & m) !== v) rd_reg(a, 32'h0, 32'h0);
    endtask : poll
    // compare each read answer with the oldest note, and cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (rd_n === 1'b1 && wreq_n === 1'b0) begin
            chk(rdat_n & msk_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        if (cyc == 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // main sequence
    initial begin
        void'($urandom(73));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_reg(2'h0, 32'hF, 32'h1);
        rd_reg(2'h1, 32'h1FF, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr_reg(2'h0, {30'h0, i[0], 1'b1});
            wr_reg(2'h1, {29'h0, mv[i / 2]});
            poll(2'h1, 32'h100, 32'h0);
            repeat (AVG_REFRESH_INTERVAL) @(posedge clk);
            r0 = refs;
            e = 4 << (i / 2 + i % 2);
            repeat (4 * AVG_REFRESH_INTERVAL) @(posedge clk);
            chk({31'h0, refs - r0 <= e + 2 && refs - r0 >= e - 2}, 32'h1);
        end
        // random walk of ten picks among the five modes, fast preference random
        for (int i = 0; i < 10; i++) begin
            r0 = $urandom % 5;
            wr_reg(2'h0, {28'h0, 1'($urandom), 3'h1});
            wr_reg(2'h1, {29'h0, mv[r0]});
            poll(2'h1, 32'h100, 32'h0);
            rd_reg(2'h1, 32'h1FF, {29'h0, mv[r0]});
            chk({29'h0, mr}, {29'h0, mv[r0]});
            repeat (AVG_REFRESH_INTERVAL) @(posedge clk);
        end
        // reserved patterns flag an error and keep the mode
        wr_reg(2'h1, 32'h0);
        poll(2'h1, 32'h100, 32'h0);
        foreach (rsv[k]) begin
            wr_reg(2'h1, {29'h0, rsv[k]});
            rd_reg(2'h3, 32'h10000, 32'h10000);
            rd_reg(2'h1, 32'h7, 32'h0);
            wr_reg(2'h3, 32'h10000);
            rd_reg(2'h3, 32'h10000, 32'h0);
        end
        // temperature controlled refresh only beside fixed single rate
        wr_reg(2'h0, 32'h5);
        @(posedge clk);
        chk({31'h0, temp_controlled_refresh}, 32'h1);
        wr_reg(2'h1, 32'h1);
        rd_reg(2'h3, 32'h20000, 32'h20000);
        rd_reg(2'h1, 32'h7, 32'h0);
        wr_reg(2'h0, 32'h1);
        wr_reg(2'h3, 32'h20000);
        wr_reg(2'h1, 32'h1);
        poll(2'h1, 32'h100, 32'h0);
        wr_reg(2'h0, 32'h5);
        rd_reg(2'h0, 32'h4, 32'h0);
        rd_reg(2'h3, 32'h20000, 32'h20000);
        // self refresh entry and exit in fixed double and fixed quad rate
        for (int k = 0; k < 2; k++) begin
            wr_reg(2'h1, {30'h0, k[0], ~k[0]});
            poll(2'h1, 32'h100, 32'h0);
            repeat ($urandom % 200) @(posedge clk);
            wr_reg(2'h2, 32'h1);
            poll(2'h3, 32'h1000, 32'h1000);
            wr_reg(2'h2, 32'h2);
            poll(2'h3, 32'h1000, 32'h0);
            repeat (AVG_REFRESH_INTERVAL) @(posedge clk);
        end
        chk(viol, 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
